// File: hw/fesh_regs.svh
`ifndef FESH_REGS_SVH
`define FESH_REGS_SVH
// ************************************************************
// command codes
// ************************************************************
`define FESH_CMD_READ_STATUS  8'h70
`define FESH_CMD_CHIP_SETUP   8'h30
`define FESH_CMD_CONFIRM      8'hd0
`define FESH_CMD_WRITE_SETUP  8'h40
`define FESH_CMD_WRITE_ALT    8'h10
`define FESH_CMD_READ_ARRAY   8'hff
`define FESH_CMD_CLEAR_STATUS 8'h50
// ************************************************************
// status_reg bit positions
// ************************************************************
`define FESH_SR_READY    7
`define FESH_SR_OP_ERR   5
`define FESH_SR_WR_ERR   4
`define FESH_SR_SUPPLY   3
`define FESH_SR_PROTECT  1
// ************************************************************
// bus timing, in ns and rounded up to 20 ns ref_clk cycles
// ************************************************************
`define FESH_T_WE_NS     60
`define FESH_WE_CYC      ((`FESH_T_WE_NS + 19) / 20)
`define FESH_T_OE_NS     100
`define FESH_OE_CYC      ((`FESH_T_OE_NS + 19) / 20)
`endif

// File: hw/fesh_pkg.sv
package fesh_pkg;
  typedef enum logic [2:0]
  {
    FESH_OP_CHIP_ERASE  = 3'h1,
    FESH_OP_WRITE       = 3'h2,
    FESH_OP_CLEAR       = 3'h3,
    FESH_OP_READ_ARRAY  = 3'h4,
    FESH_OP_STATUS_ONLY = 3'h5
  } fesh_op_t;
  typedef enum logic [3:0]
  {
    FESH_RES_OK       = 4'h0,
    FESH_RES_SUPPLY   = 4'h1,
    FESH_RES_PROTECT  = 4'h2,
    FESH_RES_SEQUENCE = 4'h3,
    FESH_RES_OP_FAIL  = 4'h4
  } fesh_res_t;
endpackage : fesh_pkg

// File: hw/fesh_bus_cycle.sv
`timescale 1ns/1ns
`default_nettype none
`include "fesh_regs.svh"
module fesh_bus_cycle
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic [19:0] addr,
  input  wire logic [15:0] wdata,
  output logic             done,
  output logic [15:0]      rdata_q,
  output logic [19:0]      mem_addr_q,
  output logic [15:0]      mem_dq_o_q,
  output logic             mem_dq_oe_q,
  input  wire logic [15:0] mem_dq_i,
  output logic             mem_ce_n_q,
  output logic             mem_we_n_q,
  output logic             mem_oe_n_q
);
  logic [3:0] cnt_q;
  logic       busy_q;
  logic       wr_q;
  logic       done_q;
  // done rises on the capture edge, together with rdata_q, so the caller never reads a stale rdata_q
  assign done = done_q;
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      done_q <= 1'b0;
    else
      done_q <= busy_q && (cnt_q == 4'h0);
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      busy_q <= 1'b0;
      cnt_q <= 4'h0;
      wr_q <= 1'b0;
      mem_addr_q <= 20'h00000;
      mem_dq_o_q <= 16'h0000;
      mem_dq_oe_q <= 1'b0;
      mem_ce_n_q <= 1'b1;
      mem_we_n_q <= 1'b1;
      mem_oe_n_q <= 1'b1;
      rdata_q <= 16'h0000;
    end
    else if (!busy_q && start)
    begin
      busy_q <= 1'b1;
      wr_q <= is_write;
      cnt_q <= is_write ? 4'(`FESH_WE_CYC) : 4'(`FESH_OE_CYC);
      mem_addr_q <= addr;
      mem_dq_o_q <= wdata;
      mem_dq_oe_q <= is_write;
      mem_ce_n_q <= 1'b0;
      mem_we_n_q <= !is_write;
      mem_oe_n_q <= is_write;
    end
    else if (busy_q)
    begin
      if (cnt_q == 4'h0)
      begin
        // data is latched on the strobe's rising edge, so dq is released on the same edge as the strobes
        busy_q <= 1'b0;
        mem_ce_n_q <= 1'b1;
        mem_we_n_q <= 1'b1;
        mem_oe_n_q <= 1'b1;
        mem_dq_oe_q <= 1'b0;
        if (!wr_q)
          rdata_q <= mem_dq_i;
      end
      else
        cnt_q <= cnt_q - 4'h1;
    end
  end
endmodule : fesh_bus_cycle
`default_nettype wire

// File: hw/fesh_host.sv
// Summary of operation
// - read-status is issued and bit 7 polled until ready before each operation except read-array; bit 7 is polled again after erase and write.
// - chip erase is a setup write then a confirm write, both at any address.
// - word write is a setup write of either code then the data at the target address.
// - the full check may run after each operation or after a series.
// - status is cleared after an error before retry.
// - the full check looks at supply, protect, sequence, then operation error in order.
// - read-array is written after the last operation.
`timescale 1ns/1ns
`default_nettype none
`include "fesh_regs.svh"
module fesh_host
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  input  wire logic [2:0]  cmd_op,
  input  wire logic        cmd_byte_code,
  input  wire logic        cmd_check,
  input  wire logic [19:0] cmd_addr,
  input  wire logic [15:0] cmd_data,
  output logic             rsp_valid_q,
  output logic [3:0]       rsp_result_q,
  output logic [7:0]       rsp_status_q,
  output logic [19:0]      mem_addr_q,
  output logic [15:0]      mem_dq_o_q,
  output logic             mem_dq_oe_q,
  input  wire logic [15:0] mem_dq_i,
  output logic             mem_ce_n_q,
  output logic             mem_we_n_q,
  output logic             mem_oe_n_q
);
  // ************************************************************
  // sequencer states
  // ************************************************************
  typedef enum logic [7:0]
  {
    FESH_S_IDLE   = 8'h01,
    FESH_S_PRE_RS = 8'h02,
    FESH_S_PRE_RD = 8'h04,
    FESH_S_WR1    = 8'h08,
    FESH_S_WR2    = 8'h10,
    FESH_S_POST   = 8'h20,
    FESH_S_ARRAY  = 8'h40,
    FESH_S_DONE   = 8'h80
  } fesh_state_t;
  fesh_state_t       state_q;
  fesh_pkg::fesh_op_t op_q;
  logic              byte_q;
  logic              check_q;
  logic [19:0]       addr_q;
  logic [15:0]       data_q;
  logic              cyc_start;
  logic              cyc_wr;
  logic [19:0]       cyc_addr;
  logic [15:0]       cyc_wdata;
  logic              cyc_done;
  logic [15:0]       cyc_rdata;
  logic              issued_q;
  // ************************************************************
  // status decode, checked in fixed priority order
  // ************************************************************
  function automatic fesh_pkg::fesh_res_t fesh_decode(input logic [7:0] sr);
    if (sr[`FESH_SR_SUPPLY])
      return fesh_pkg::FESH_RES_SUPPLY;
    else if (sr[`FESH_SR_PROTECT])
      return fesh_pkg::FESH_RES_PROTECT;
    else if (sr[`FESH_SR_OP_ERR] && sr[`FESH_SR_WR_ERR])
      return fesh_pkg::FESH_RES_SEQUENCE;
    else if (sr[`FESH_SR_OP_ERR] || sr[`FESH_SR_WR_ERR])
      return fesh_pkg::FESH_RES_OP_FAIL;
    else
      return fesh_pkg::FESH_RES_OK;
  endfunction : fesh_decode
  assign cmd_ready = (state_q == FESH_S_IDLE);
  fesh_bus_cycle u_cycle
  (
    .ref_clk     (ref_clk),
    .rst         (rst),
    .start       (cyc_start),
    .is_write    (cyc_wr),
    .addr        (cyc_addr),
    .wdata       (cyc_wdata),
    .done        (cyc_done),
    .rdata_q     (cyc_rdata),
    .mem_addr_q  (mem_addr_q),
    .mem_dq_o_q  (mem_dq_o_q),
    .mem_dq_oe_q (mem_dq_oe_q),
    .mem_dq_i    (mem_dq_i),
    .mem_ce_n_q  (mem_ce_n_q),
    .mem_we_n_q  (mem_we_n_q),
    .mem_oe_n_q  (mem_oe_n_q)
  );
  // ************************************************************
  // bus cycle selection per state
  // ************************************************************
  always_comb
  begin
    cyc_start = 1'b0;
    cyc_wr = 1'b1;
    cyc_addr = addr_q;
    cyc_wdata = 16'h0000;
    case (state_q)
      FESH_S_PRE_RS:
      begin
        cyc_start = !issued_q;
        cyc_wdata = {8'h00, `FESH_CMD_READ_STATUS};
      end
      FESH_S_PRE_RD, FESH_S_POST:
      begin
        // status stays readable after the command write, so polling is reads only
        cyc_start = !issued_q;
        cyc_wr = 1'b0;
      end
      FESH_S_WR1:
      begin
        cyc_start = !issued_q;
        if (op_q == fesh_pkg::FESH_OP_CHIP_ERASE)
          cyc_wdata = {8'h00, `FESH_CMD_CHIP_SETUP};
        else if (op_q == fesh_pkg::FESH_OP_WRITE)
          cyc_wdata = {8'h00, byte_q ? `FESH_CMD_WRITE_ALT : `FESH_CMD_WRITE_SETUP};
        else
          cyc_wdata = {8'h00, `FESH_CMD_CLEAR_STATUS};
      end
      FESH_S_WR2:
      begin
        cyc_start = !issued_q;
        if (op_q == fesh_pkg::FESH_OP_CHIP_ERASE)
          cyc_wdata = {8'h00, `FESH_CMD_CONFIRM};
        else
          cyc_wdata = data_q;
      end
      FESH_S_ARRAY:
      begin
        cyc_start = !issued_q;
        cyc_wdata = {8'h00, `FESH_CMD_READ_ARRAY};
      end
      default:
      begin
        cyc_start = 1'b0;
      end
    endcase
  end
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      issued_q <= 1'b0;
    else if (cyc_done)
      issued_q <= 1'b0;
    else if (cyc_start)
      issued_q <= 1'b1;
  end
  // ************************************************************
  // request capture
  // ************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      op_q <= fesh_pkg::FESH_OP_STATUS_ONLY;
      byte_q <= 1'b0;
      check_q <= 1'b0;
      addr_q <= 20'h00000;
      data_q <= 16'h0000;
    end
    else if (cmd_valid && cmd_ready)
    begin
      op_q <= fesh_pkg::fesh_op_t'(cmd_op);
      byte_q <= cmd_byte_code;
      check_q <= cmd_check;
      addr_q <= cmd_addr;
      data_q <= cmd_data;
    end
  end
  // ************************************************************
  // sequencer
  // ************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      state_q <= FESH_S_IDLE;
    else
      case (state_q)
        FESH_S_IDLE:
          if (cmd_valid)
            state_q <= (fesh_pkg::fesh_op_t'(cmd_op) == fesh_pkg::FESH_OP_READ_ARRAY) ? FESH_S_ARRAY : FESH_S_PRE_RS;
        FESH_S_PRE_RS:
          if (cyc_done)
            state_q <= FESH_S_PRE_RD;
        FESH_S_PRE_RD:
          if (cyc_done && cyc_rdata[`FESH_SR_READY])
            state_q <= (op_q == fesh_pkg::FESH_OP_STATUS_ONLY) ? FESH_S_DONE : FESH_S_WR1;
        FESH_S_WR1:
          if (cyc_done)
            state_q <= (op_q == fesh_pkg::FESH_OP_CLEAR) ? FESH_S_DONE : FESH_S_WR2;
        FESH_S_WR2:
          if (cyc_done)
            state_q <= FESH_S_POST;
        FESH_S_POST:
          if (cyc_done && cyc_rdata[`FESH_SR_READY])
            state_q <= FESH_S_DONE;
        FESH_S_ARRAY:
          if (cyc_done)
            state_q <= FESH_S_DONE;
        default:
          state_q <= FESH_S_IDLE;
      endcase
  end
  // ************************************************************
  // response; the decode is skipped when the caller defers the check
  // ************************************************************
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rsp_valid_q <= 1'b0;
      rsp_result_q <= 4'h0;
      rsp_status_q <= 8'h00;
    end
    else
    begin
      rsp_valid_q <= 1'b0;
      if (state_q == FESH_S_DONE)
      begin
        rsp_valid_q <= 1'b1;
        rsp_status_q <= cyc_rdata[7:0];
        if (check_q && (op_q != fesh_pkg::FESH_OP_READ_ARRAY) && (op_q != fesh_pkg::FESH_OP_CLEAR))
          rsp_result_q <= fesh_decode(cyc_rdata[7:0]);
        else
          rsp_result_q <= fesh_pkg::FESH_RES_OK;
      end
    end
  end
endmodule : fesh_host
`default_nettype wire

// File: test/fesh_flash_model.sv
`timescale 1ns/1ns
`default_nettype none
module fesh_flash_model
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [2:0]  err,
  input  wire logic        slow,
  input  wire logic [19:0] mem_addr_q,
  input  wire logic [15:0] mem_dq_o_q,
  input  wire logic        mem_ce_n_q,
  input  wire logic        mem_we_n_q,
  input  wire logic        mem_oe_n_q,
  output logic      [15:0] mem_dq_i
);
  // ************
  // device state
  // ************
  logic [7:0]  sr_q;
  logic [1:0]  mode_q;
  logic [3:0]  busy_q;
  logic        we_q;
  logic        erased_q;
  logic [19:0] a_q;
  logic [19:0] waddr_q;
  logic [15:0] d_q;
  logic [15:0] wdata_q;
  logic [15:0] last_q;
  wire  [7:0]  c = d_q[7:0];
  // released bus shows a changing pattern, not the last value
  assign mem_dq_i = (!mem_oe_n_q && !mem_ce_n_q) ? ((mode_q == 2'h0) ? wdata_q
    : {8'h00, busy_q == 4'h0, sr_q[6:0]}) : ~last_q;
  always_ff @(posedge ref_clk)
  begin
    we_q   <= mem_we_n_q;
    a_q    <= mem_addr_q;
    d_q    <= mem_dq_o_q;
    last_q <= mem_dq_i;
    if (busy_q != 4'h0) busy_q <= busy_q - 4'h1;
    if (rst)
    begin
      sr_q     <= 8'h00;
      mode_q   <= 2'h0;
      busy_q   <= 4'h0;
      erased_q <= 1'b0;
    end
    else if (!we_q && mem_we_n_q)
    begin
      mode_q <= 2'h1;
      if (mode_q[1])
      begin
        busy_q <= slow ? 4'hf : 4'h2;
        // error bits only ever set here, so they stay until clear
        if (mode_q == 2'h2 && (c != 8'hd0 || err == 3'h4)) sr_q[5:4] <= 2'h3;
        else if (err == 3'h1) sr_q[3] <= 1'b1;
        else if (err == 3'h2) sr_q[1] <= 1'b1;
        else if (err == 3'h3) sr_q[mode_q == 2'h2 ? 5 : 4] <= 1'b1;
        else if (mode_q == 2'h2) erased_q <= 1'b1;
        else
        begin
          waddr_q <= a_q;
          wdata_q <= d_q;
        end
      end
      else
        case (c)
          8'h30:        mode_q <= 2'h2;
          8'h40, 8'h10: mode_q <= 2'h3;
          8'hff:        mode_q <= 2'h0;
          8'h50:        sr_q   <= 8'h00;
          default:      ;
        endcase
    end
  end
endmodule : fesh_flash_model
`default_nettype wire

// File: test/fesh_host_chk.sv
`timescale 1ns/1ns
`default_nettype none
module fesh_host_chk
(
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wire logic        cmd_ready,
  input wire logic [2:0]  cmd_op,
  input wire logic        rsp_valid_q,
  input wire logic [3:0]  rsp_result_q,
  input wire logic [19:0] mem_addr_q,
  input wire logic [15:0] mem_dq_o_q,
  input wire logic        mem_dq_oe_q,
  input wire logic        mem_ce_n_q,
  input wire logic        mem_we_n_q,
  input wire logic        mem_oe_n_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire take = cmd_valid && cmd_ready;
  chk_rsp_single: assert property (rsp_valid_q |=> !rsp_valid_q)
    else $error("response pulse too long");
  chk_take_busy: assert property (take |=> !cmd_ready)
    else $error("ready after take");
  chk_first_status: assert property (take && cmd_op != 3'h4 |-> ##2 (!mem_we_n_q && mem_dq_o_q == 16'h0070))
    else $error("no read-status first");
  chk_array_cmd: assert property (take && cmd_op == 3'h4 |-> ##2 (!mem_we_n_q && mem_dq_o_q == 16'h00ff))
    else $error("no read-array write");
  chk_we_pulse: assert property ($fell(mem_we_n_q) |-> (!mem_we_n_q)[*4] ##1 mem_we_n_q)
    else $error("write pulse width");
  chk_oe_pulse: assert property ($fell(mem_oe_n_q) |-> (!mem_oe_n_q)[*6] ##1 mem_oe_n_q)
    else $error("read pulse width");
  chk_no_fight: assert property (!mem_oe_n_q |-> !mem_dq_oe_q && !mem_ce_n_q && mem_we_n_q)
    else $error("bus contention");
  chk_cmd_hold: assert property (!mem_we_n_q && $past(!mem_we_n_q) |-> $stable(mem_dq_o_q) && $stable(mem_addr_q))
    else $error("write data moved");
  chk_reset_idle: assert property (@(posedge ref_clk) disable iff (1'b0) rst |=> mem_we_n_q && mem_oe_n_q && !rsp_valid_q)
    else $error("strobes not idle in reset");
  cov_erase: cover property (take && cmd_op == 3'h1);
  cov_write: cover property (take && cmd_op == 3'h2);
  cov_error: cover property (rsp_valid_q && rsp_result_q != 4'h0);
endmodule : fesh_host_chk
bind fesh_host fesh_host_chk i_fesh_host_chk (.ref_clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .rsp_valid_q,
  .rsp_result_q, .mem_addr_q, .mem_dq_o_q, .mem_dq_oe_q, .mem_ce_n_q, .mem_we_n_q, .mem_oe_n_q);
`default_nettype wire

// File: test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  typedef struct packed {logic [2:0] op; logic bc; logic ck; logic [2:0] err; logic [3:0] res; logic [7:0] st;} fesh_row_t;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        cmd_valid = 1'b0;
  logic [2:0]  cmd_op = 3'h5;
  logic        cmd_byte_code = 1'b0;
  logic        cmd_check = 1'b0;
  logic [19:0] cmd_addr = 20'h0;
  logic [15:0] cmd_data = 16'h0;
  logic [2:0]  err = 3'h0;
  logic        slow = 1'b0;
  logic        cmd_ready, rsp_valid_q, mem_dq_oe_q, mem_ce_n_q, mem_we_n_q, mem_oe_n_q;
  logic [3:0]  rsp_result_q;
  logic [7:0]  rsp_status_q;
  logic [19:0] mem_addr_q;
  logic [15:0] mem_dq_o_q, mem_dq_i;
  int          n_errors = 0, comparisons = 0, cyc = 0;
  // sticky bits make row order matter: each row sees what earlier rows left
  fesh_row_t rows [16] = '{
    {3'h2,1'b0,1'b1,3'h0,4'h0,8'h80}, {3'h2,1'b1,1'b1,3'h1,4'h1,8'h88}, {3'h5,1'b0,1'b1,3'h0,4'h1,8'h88},
    {3'h3,1'b0,1'b0,3'h0,4'h0,8'h88}, {3'h1,1'b0,1'b1,3'h2,4'h2,8'h82}, {3'h3,1'b0,1'b0,3'h0,4'h0,8'h82},
    {3'h1,1'b0,1'b1,3'h3,4'h4,8'ha0}, {3'h2,1'b0,1'b0,3'h1,4'h0,8'ha8}, {3'h5,1'b0,1'b1,3'h0,4'h1,8'ha8},
    {3'h3,1'b0,1'b0,3'h0,4'h0,8'ha8}, {3'h1,1'b0,1'b1,3'h4,4'h3,8'hb0}, {3'h3,1'b0,1'b0,3'h0,4'h0,8'hb0},
    {3'h2,1'b0,1'b1,3'h3,4'h4,8'h90}, {3'h3,1'b0,1'b0,3'h0,4'h0,8'h90}, {3'h5,1'b0,1'b1,3'h0,4'h0,8'h80},
    {3'h1,1'b0,1'b1,3'h0,4'h0,8'h80}};
  fesh_host i_fesh_host (.ref_clk, .rst, .cmd_valid, .cmd_ready, .cmd_op, .cmd_byte_code, .cmd_check, .cmd_addr,
    .cmd_data, .rsp_valid_q, .rsp_result_q, .rsp_status_q, .mem_addr_q, .mem_dq_o_q, .mem_dq_oe_q, .mem_dq_i,
    .mem_ce_n_q, .mem_we_n_q, .mem_oe_n_q);
  fesh_flash_model i_fesh_flash_model (.ref_clk, .rst, .err, .slow, .mem_addr_q, .mem_dq_o_q, .mem_ce_n_q,
    .mem_we_n_q, .mem_oe_n_q, .mem_dq_i);
  always #10 ref_clk = ~ref_clk;
  task check(input logic ok);
    comparisons++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("unexpected at %0t: value mismatch", $time);
    end
  endtask : check
  task report_and_stop;
    $display("n_errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc > 20000)
    begin
      n_errors++;
      report_and_stop;
    end
  end
  // request held until the edge that takes it, then released
  task run_op(input fesh_row_t r, input logic [19:0] a);
    @(posedge ref_clk);
    {cmd_op, cmd_byte_code, cmd_check, err} <= {r.op, r.bc, r.ck, r.err};
    cmd_addr  <= a;
    cmd_data  <= ~a[15:0];
    cmd_valid <= 1'b1;
    do @(negedge ref_clk); while (cmd_ready !== 1'b1);
    @(posedge ref_clk);
    cmd_valid <= 1'b0;
    do @(negedge ref_clk); while (rsp_valid_q !== 1'b1);
  endtask : run_op
  initial
  begin
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    check(cmd_ready === 1'b1 && mem_we_n_q === 1'b1);
    for (int i = 0; i < 16; i++)
    begin
      slow <= i[0];
      if (i == 15) check(i_fesh_flash_model.erased_q === 1'b0);
      run_op(rows[i], 20'h1230 + 20'(i));
      check(rsp_result_q === rows[i].res && rsp_status_q === rows[i].st);
      if (i == 0) check(i_fesh_flash_model.wdata_q === ~16'h1230 && i_fesh_flash_model.waddr_q === 20'h1230);
    end
    check(i_fesh_flash_model.erased_q === 1'b1);
    run_op(rows[15] ^ {3'h5, 17'h00000}, 20'h0);
    check(i_fesh_flash_model.mode_q === 2'h0 && i_fesh_flash_model.sr_q === 8'h00);
    @(posedge ref_clk);
    {cmd_op, cmd_valid} <= {3'h2, 1'b1};
    repeat (9) @(posedge ref_clk);
    {rst, cmd_valid} <= 2'b10;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    check(cmd_ready === 1'b1 && mem_we_n_q === 1'b1 && mem_oe_n_q === 1'b1);
    run_op(rows[14], 20'h0);
    check(rsp_result_q === 4'h0 && rsp_status_q === 8'h80);
    report_and_stop;
  end
endmodule : tb_top
`default_nettype wire
